// File: rtl/plio_pkg.sv
// package: constants, modes and carriers for the pump logic i/o control unit
`default_nettype none
package plio_pkg;

  // =========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_OUTPUT  = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_PROGCMD = 8'h0c;
  localparam logic [7:0] OFF_PROGRES = 8'h10;

  // ctrl field positions
  localparam int CTRL_TRG_LSB = 0;   // 4-bit trigger mode
  localparam int CTRL_DIN_BIT = 4;   // direction input mode
  localparam int CTRL_ROM_BIT = 5;   // motor output mode
  localparam int CTRL_EDIT_BIT = 6;  // keypad edit in progress
  localparam int CTRL_ALARM_BIT = 7; // alarm present

  // reset values
  localparam logic [3:0] TRG_RESET = 4'h0;

  // =========================================================
  // timing: stability filter
  localparam int CLK_HZ        = 100_000_000;
  localparam int STABLE_MS     = 100;
  localparam int STABLE_CYCLES = (CLK_HZ / 1000) * STABLE_MS;

  // =========================================================
  // trigger modes
  typedef enum logic [3:0] {
    TRG_FOOTPEDAL_TOGGLE, TRG_PEDAL_HOLD_RUN, TRG_PEDAL_TOGGLE_RISING,
    TRG_EDGE_PAIR_RUN_CONTROL, TRG_BEGIN_ONLY_FALLING, TRG_BEGIN_ONLY_RISING,
    TRG_HALT_ONLY_FALLING, TRG_HALT_ONLY_RISING, TRG_RUN_WHILE_LOW,
    TRG_RUN_WHILE_HIGH, TRG_HALT_WHILE_LOW, TRG_HALT_WHILE_HIGH,
    TRG_TRIGGER_DISABLED, TRG_TRAP_REDIRECT_HALT, TRG_KEY_HALT_REDIRECT
  } plio_trg_t;

  // program engine command codes
  typedef enum logic [2:0] {
    PCMD_NONE, PCMD_OUT_SET, PCMD_ARM_FALL, PCMD_ARM_EITHER,
    PCMD_DISARM, PCMD_LOW_JUMP, PCMD_WAIT_TRIG
  } plio_pcmd_t;

  // filtered input bundle
  typedef struct packed {
    logic trig;
    logic dir;
    logic evt;
    logic prog;
  } plio_in_t;

  // engine status carrier
  typedef struct packed {
    logic pumping;
    logic pauseTimer;
    logic dirInfuse;
    logic keyDirOk;
    logic stopKey;
  } plio_eng_t;

endpackage
`default_nettype wire

// File: rtl/plio_control.sv
// pump logic i/o control: input filtering, trigger, direction and program i/o
`default_nettype none

// What this block does
// - halt-only falling: fall stops, never starts
// - halt-only rising: rise stops, else ignored
// - halt-while modes keep pump stopped at level
// - disabled mode ignores trigger input entirely
// - trap-redirect sends trigger stop to trap
// - key-redirect sends stop key to trap
// - motor mode 0: high only while pumping
// - motor mode 1: high pumping or pause timer
// - direction input acts like direction key
// - opposite pair: fall infuses, rise withdraws
// - same pair: rise infuses, fall withdraws
// - direction output low withdraw, high infuse
// - output-set function drives program output pin
// - armed falling jump: event fall jumps phase
// - armed either-edge jump: any event edge jumps
// - low-input jump branches on program input low
// - zero pause waits for trigger then resumes
// - input levels readable by query command
// - program output settable by serial command
// - trigger, direction, motor modes selectable
// - ignore trigger, direction during edit or alarm
// - level needs 100 ms stability before recognised
// - pedal toggle: each fall starts or stops
// - edge pair: rise starts, fall stops
module plio_control
  import plio_pkg::*;
#(
  parameter int STABLE_CNT = STABLE_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // connector pins
  input  wire logic                trigPin,
  input  wire logic                dirPin,
  input  wire logic                evtPin,
  input  wire logic                progPin,
  output logic                     motorOut,
  output logic                     dirOut,
  output logic                     progOut,
  // program engine side
  input  wire plio_pkg::plio_eng_t eng,
  output logic                     startReq,
  output logic                     stopReq,
  output logic                     trapReq,
  output logic                     dirToggle,
  output logic                     jumpReq,
  output logic [7:0]               jumpPhase,
  output logic                     resumeReq
);

  // =========================================================
  // synchronisers and stability filters
  logic [3:0] rawIn;
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] filt_r;
  logic [3:0] prevFilt_r;
  logic [31:0] stabCnt_r [4];
  plio_in_t    inF;

  assign rawIn = {trigPin, dirPin, evtPin, progPin};
  assign inF   = plio_in_t'(filt_r);

  // two-stage synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
    end else begin
      meta_r <= rawIn;
      sync_r <= meta_r;
    end
  end

  // per-input level filter: level must hold STABLE_CNT cycles
  for (genvar i = 0; i < 4; i++) begin : g_filt
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        stabCnt_r[i] <= 32'h0;
        filt_r[i]    <= 1'b0;
      end else if (sync_r[i] == filt_r[i]) begin
        stabCnt_r[i] <= 32'h0;
      end else if (stabCnt_r[i] >= 32'(STABLE_CNT - 1)) begin
        stabCnt_r[i] <= 32'h0;
        filt_r[i]    <= sync_r[i];
      end else begin
        stabCnt_r[i] <= stabCnt_r[i] + 32'h1;
      end
    end
  end

  // previous filtered level for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) prevFilt_r <= 4'h0;
    else     prevFilt_r <= filt_r;
  end

  // edges of the filtered levels; filters start low, so reset gives no edge
  logic [3:0] rise;
  logic [3:0] fall;
  assign rise = filt_r & ~prevFilt_r;
  assign fall = ~filt_r & prevFilt_r;
  plio_in_t riseS;
  plio_in_t fallS;
  assign riseS = plio_in_t'(rise);
  assign fallS = plio_in_t'(fall);

  // =========================================================
  // registers
  logic [3:0] trgMode_r;
  logic       dinMode_r;
  logic       romMode_r;
  logic       editing_r;
  logic       alarm_r;
  logic       outSw_r;
  logic       evFallArm_r;
  logic       evEitherArm_r;
  logic [7:0] evPhase_r;
  logic       waitTrig_r;
  logic       lowJumpTaken_r;
  logic       lowJumpDone_r;
  logic [7:0] lowPhase_r;

  // trigger decode results, also read by the zero-pause logic
  logic       trigStart;
  logic       trigStop;
  logic       trigAct;

  // bus write strobe and decoded control
  logic       wrEn;
  plio_trg_t  trigger_default_select;
  logic       extBlock;
  assign wrEn     = psel && penable && pwrite;
  assign trigger_default_select      = plio_trg_t'(trgMode_r);
  assign extBlock = editing_r || alarm_r;

  // the five mapped words; anything else answers with pslverr
  logic mapped;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_OUTPUT) || (paddr == OFF_STATUS)
               || (paddr == OFF_PROGCMD) || (paddr == OFF_PROGRES);

  // configuration register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trgMode_r <= TRG_RESET;
      dinMode_r <= 1'b0;
      romMode_r <= 1'b0;
      editing_r <= 1'b0;
      alarm_r   <= 1'b0;
    end else if (wrEn && paddr == OFF_CTRL) begin
      // out-of-range trigger codes are refused, mode kept
      if (pwdata[CTRL_TRG_LSB +: 4] <= 4'he) trgMode_r <= pwdata[CTRL_TRG_LSB +: 4];
      dinMode_r <= pwdata[CTRL_DIN_BIT];
      romMode_r <= pwdata[CTRL_ROM_BIT];
      editing_r <= pwdata[CTRL_EDIT_BIT];
      alarm_r   <= pwdata[CTRL_ALARM_BIT];
    end
  end

  // program output: serial write or program function
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outSw_r <= 1'b0;
    end else if (wrEn && paddr == OFF_OUTPUT) begin
      outSw_r <= pwdata[0];
    end else if (wrEn && paddr == OFF_PROGCMD && plio_pcmd_t'(pwdata[2:0]) == PCMD_OUT_SET) begin
      outSw_r <= pwdata[8];
    end
  end

  // program function decode from the command word
  logic       cmdWr;
  plio_pcmd_t cmd;
  assign cmdWr = wrEn && paddr == OFF_PROGCMD;
  assign cmd   = plio_pcmd_t'(pwdata[2:0]);

  // event jump arming: one mode at a time, phase kept on disarm
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evFallArm_r   <= 1'b0;
      evEitherArm_r <= 1'b0;
      evPhase_r     <= 8'h00;
    end else if (cmdWr) begin
      case (cmd)
        PCMD_ARM_FALL: begin
          evFallArm_r   <= 1'b1;
          evEitherArm_r <= 1'b0;
          evPhase_r     <= pwdata[15:8];
        end
        PCMD_ARM_EITHER: begin
          evFallArm_r   <= 1'b0;
          evEitherArm_r <= 1'b1;
          evPhase_r     <= pwdata[15:8];
        end
        PCMD_DISARM: begin
          evFallArm_r   <= 1'b0;
          evEitherArm_r <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // low-input jump: program input judged once, when the function executes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowJumpTaken_r <= 1'b0;
      lowJumpDone_r  <= 1'b0;
      lowPhase_r     <= 8'h00;
    end else if (cmdWr && cmd == PCMD_LOW_JUMP) begin
      lowJumpTaken_r <= !inF.prog;
      lowJumpDone_r  <= 1'b1;
      lowPhase_r     <= pwdata[15:8];
    end
  end

  // zero pause: set by the function, cleared by the next trigger activation;
  // a fresh set wins over a clear, and unrelated writes never hold a clear off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitTrig_r <= 1'b0;
    end else if (cmdWr && cmd == PCMD_WAIT_TRIG) begin
      waitTrig_r <= 1'b1;
    end else if (waitTrig_r && trigAct) begin
      waitTrig_r <= 1'b0;
    end
  end

  // =========================================================
  // trigger decode

  // trigger activation by mode, blocked during edit or alarm
  always_comb begin
    trigStart = 1'b0;
    trigStop  = 1'b0;
    case (trigger_default_select)
      TRG_FOOTPEDAL_TOGGLE: begin
        trigStart = fallS.trig && !eng.pumping;
        trigStop  = fallS.trig && eng.pumping;
      end
      TRG_PEDAL_HOLD_RUN: begin
        trigStart = fallS.trig;
        trigStop  = riseS.trig;
      end
      TRG_PEDAL_TOGGLE_RISING: begin
        trigStart = riseS.trig && !eng.pumping;
        trigStop  = riseS.trig && eng.pumping;
      end
      TRG_EDGE_PAIR_RUN_CONTROL: begin
        trigStart = riseS.trig;
        trigStop  = fallS.trig;
      end
      TRG_BEGIN_ONLY_FALLING: trigStart = fallS.trig;
      TRG_BEGIN_ONLY_RISING:  trigStart = riseS.trig;
      TRG_HALT_ONLY_FALLING:  trigStop  = fallS.trig;
      TRG_HALT_ONLY_RISING:   trigStop  = riseS.trig;
      TRG_RUN_WHILE_LOW:      trigStart = !inF.trig && !eng.pumping;
      TRG_RUN_WHILE_HIGH:     trigStart = inF.trig && !eng.pumping;
      TRG_HALT_WHILE_LOW:     trigStop  = !inF.trig && eng.pumping;
      TRG_HALT_WHILE_HIGH:    trigStop  = inF.trig && eng.pumping;
      TRG_TRAP_REDIRECT_HALT: trigStop  = fallS.trig;  // stop source, rerouted
      TRG_TRIGGER_DISABLED:   ;
      default:                ;
    endcase
    if (extBlock) begin
      trigStart = 1'b0;
      trigStop  = 1'b0;
    end
  end
  assign trigAct = trigStart || trigStop;

  // =========================================================
  // direction input decode
  logic dirChange;
  always_comb begin
    dirChange = 1'b0;
    if (!dinMode_r) begin
      dirChange = eng.dirInfuse ? riseS.dir : fallS.dir;
    end else begin
      dirChange = eng.dirInfuse ? fallS.dir : riseS.dir;
    end
    if (extBlock || !eng.keyDirOk) dirChange = 1'b0;
  end

  // =========================================================
  // engine request outputs, registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startReq  <= 1'b0;
      stopReq   <= 1'b0;
      trapReq   <= 1'b0;
      dirToggle <= 1'b0;
      resumeReq <= 1'b0;
    end else begin
      // zero pause consumes trigger activation as resume
      resumeReq <= waitTrig_r && trigAct;
      startReq  <= trigStart && !waitTrig_r;
      stopReq   <= trigStop && !waitTrig_r && trigger_default_select != TRG_TRAP_REDIRECT_HALT;
      // key redirect stays live during edit or alarm
      trapReq   <= (trigStop && !waitTrig_r && trigger_default_select == TRG_TRAP_REDIRECT_HALT)
                || (eng.stopKey && trigger_default_select == TRG_KEY_HALT_REDIRECT);
      dirToggle <= dirChange;
    end
  end

  // event jump outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      jumpReq   <= 1'b0;
      jumpPhase <= 8'h00;
    end else begin
      jumpReq   <= (evFallArm_r && fallS.evt)
                || (evEitherArm_r && (fallS.evt || riseS.evt));
      jumpPhase <= evPhase_r;
    end
  end

  // pin outputs
  // levels lag engine state and registers by one clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      motorOut <= 1'b0;
      dirOut   <= 1'b0;
      progOut  <= 1'b0;
    end else begin
      motorOut <= romMode_r ? (eng.pumping || eng.pauseTimer) : eng.pumping;
      dirOut   <= eng.dirInfuse;
      progOut  <= outSw_r;
    end
  end

  // =========================================================
  // apb read path, zero wait states
  // pready answers in the first access cycle with data of the setup cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFF_CTRL:    prdata <= {24'h0, alarm_r, editing_r, romMode_r, dinMode_r, trgMode_r};
          OFF_OUTPUT:  prdata <= {31'h0, outSw_r};
          OFF_STATUS:  prdata <= {28'h0, inF.trig, inF.dir, inF.evt, inF.prog};
          OFF_PROGCMD: prdata <= {22'h0, waitTrig_r, evEitherArm_r, evFallArm_r, 7'h0};
          OFF_PROGRES: prdata <= {16'h0, lowPhase_r, 6'h0, lowJumpDone_r, lowJumpTaken_r};
          default:     prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/plio_control_assertions.sv
// concurrent checks on the pump logic i/o control unit ports
`default_nettype none
module plio_control_assertions
  import plio_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire plio_pkg::plio_eng_t eng,
  input wire logic                motorOut,
  input wire logic                dirOut,
  input wire logic                startReq,
  input wire logic                stopReq,
  input wire logic                trapReq,
  input wire logic                dirToggle
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // shadow of the control register, calm once two edges past its last write
  logic [7:0] ctrlR;
  logic [1:0] age;
  logic       calm;
  assign calm = age[1];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrlR <= 8'h00;
      age   <= 2'h0;
    end else if (psel && penable && pwrite && pready && paddr == OFF_CTRL) begin
      // a refused trigger code keeps the old mode, as the control register does
      ctrlR <= (pwdata[3:0] == 4'hf) ? {pwdata[7:4], ctrlR[3:0]} : pwdata[7:0];
      age   <= 2'h0;
    end else if (!calm) begin
      age <= age + 2'h1;
    end
  end
  // ==========
  // port relations
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_ready_first: assert property (psel && penable && $past(psel && !penable) |-> pready)
    else $error("no ready in first access cycle");
  a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access without error");
  a_dir_level: assert property (!$past(rst) |-> dirOut == $past(eng.dirInfuse))
    else $error("direction output wrong");
  a_motor_mode: assert property (!$past(rst) |->
    motorOut == $past(eng.pumping || (ctrlR[5] && eng.pauseTimer)))
    else $error("motor output wrong");
  a_disabled_quiet: assert property (calm && ctrlR[3:0] == 4'hc |->
    !(startReq || stopReq || trapReq)) else $error("request while trigger off");
  a_halt_nostart: assert property (calm && ctrlR[3:0] inside {4'h6, 4'h7, 4'ha, 4'hb}
    |-> !startReq) else $error("start in halt mode");
  a_trap_nostop: assert property (calm && ctrlR[3:0] == 4'hd |-> !stopReq)
    else $error("stop in trap mode");
  a_key_trap: assert property (calm && ctrlR[3:0] == 4'he && eng.stopKey |-> ##[1:2] trapReq)
    else $error("stop key not trapped");
  a_lock_quiet: assert property (calm && (ctrlR[6] || ctrlR[7]) |->
    !(startReq || stopReq || dirToggle)) else $error("request while locked");
  a_dir_gate: assert property (dirToggle |-> $past(eng.keyDirOk))
    else $error("toggle while key not accepted");
  c_start: cover property (startReq);
  c_dir: cover property (dirToggle);
  c_err: cover property (pslverr);
endmodule
bind plio_control plio_control_assertions plio_control_assertions_i (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .eng(eng),
  .motorOut(motorOut), .dirOut(dirOut), .startReq(startReq), .stopReq(stopReq),
  .trapReq(trapReq), .dirToggle(dirToggle)
);
`default_nettype wire

// File: verif/plio_switch_model.sv
// connector-side model: switches and automation logic on the input pins
`default_nettype none
module plio_switch_model #(
  parameter int GAP = 6
) (
  input  wire logic ref_clk,
  output var logic  trigPin,
  output var logic  dirPin,
  output var logic  evtPin,
  output var logic  progPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // pins rest low until a scenario moves them
  initial begin
    {trigPin, dirPin, evtPin, progPin} = 4'h0;
  end
  // one edge per call, made GAP clocks after the call, so at least GAP clocks after the previous edge
  task automatic set(input int idx, input logic v);
    repeat (GAP) @(posedge ref_clk);
    case (idx)
      0: trigPin <= v;
      1: dirPin <= v;
      2: evtPin <= v;
      default: progPin <= v;
    endcase
  endtask
endmodule
`default_nettype wire

// File: verif/tb_plio_control.sv
// self-checking bench for the pump logic i/o control unit
`default_nettype none
module tb_plio_control;
  timeunit 1ns;
  timeprecision 1ns;
  import plio_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, errBus;
  logic [7:0]  paddr, jumpPhase;
  logic [31:0] pwdata, prdata, rd;
  logic        trigPin, dirPin, evtPin, progPin, motorOut, dirOut, progOut;
  logic        startReq, stopReq, trapReq, dirToggle, jumpReq, resumeReq;
  logic [5:0]  pul;
  plio_eng_t   eng;
  int          err_total = 0;
  int          total_checks = 0;
  int          cnt [6] = '{default: 0};
  int          base [6];
  // control value, then start/stop/trap expected on rise and on fall
  logic [13:0] trgTab [8] = '{{8'h00, 6'h04}, {8'h03, 6'h22}, {8'h06, 6'h02},
    {8'h07, 6'h10}, {8'h0c, 6'h00}, {8'h0d, 6'h01}, {8'h43, 6'h00}, {8'h83, 6'h00}};
  // same-pair mode, infuse, key ok, toggle on rise, toggle on fall
  logic [4:0]  dirTab [5] = '{5'h05, 5'h0e, 5'h16, 5'h1d, 5'h00};

  plio_control #(.STABLE_CNT(8)) plio_control_i (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .trigPin(trigPin), .dirPin(dirPin), .evtPin(evtPin), .progPin(progPin),
    .motorOut(motorOut), .dirOut(dirOut), .progOut(progOut), .eng(eng),
    .startReq(startReq), .stopReq(stopReq), .trapReq(trapReq), .dirToggle(dirToggle),
    .jumpReq(jumpReq), .jumpPhase(jumpPhase), .resumeReq(resumeReq));
  plio_switch_model #(.GAP(6)) plio_switch_model_i (.ref_clk(ref_clk), .trigPin(trigPin),
    .dirPin(dirPin), .evtPin(evtPin), .progPin(progPin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // counts every request pulse
  assign pul = {resumeReq, jumpReq, dirToggle, trapReq, stopReq, startReq};
  always @(posedge ref_clk) begin
    for (int i = 0; i < 6; i++) if (pul[i] === 1'b1) cnt[i] <= cnt[i] + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until ready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      tick(1);
    end
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    errBus = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic ctl(input logic [7:0] v);
    apb(1'b1, OFF_CTRL, {24'h0, v});
  endtask
  // raise then drop a pin, judging three pulse counters after each edge
  task automatic rise_fall(input int pin, input int c, input logic [5:0] e);
    for (int k = 0; k < 2; k++) begin
      base = cnt;
      plio_switch_model_i.set(pin, k == 0);
      tick(14);
      for (int j = 0; j < 3; j++) check(32'(cnt[c + j] - base[c + j]), {31'h0, e[5 - 3 * k - j]});
    end
  endtask
  task automatic t_regs();
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    ctl(8'h3b);
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rd, 32'h3b);
    apb(1'b1, OFF_STATUS, 32'hf);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], errBus}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_out();
    eng.pauseTimer <= 1'b1;
    ctl(8'h2c);
    tick(2);
    check({31'h0, motorOut}, 32'h1);
    ctl(8'h0c);
    tick(2);
    check({31'h0, motorOut}, 32'h0);
    eng.pumping <= 1'b1;
    eng.dirInfuse <= 1'b1;
    tick(2);
    check({30'h0, motorOut, dirOut}, 32'h3);
    eng <= '0;
    apb(1'b1, OFF_OUTPUT, 32'h1);
    tick(1);
    check({30'h0, progOut, dirOut}, 32'h2);
    apb(1'b1, OFF_PROGCMD, 32'h001);
    tick(1);
    check({31'h0, progOut}, 32'h0);
    apb(1'b1, OFF_PROGCMD, 32'h101);
    tick(1);
    check({31'h0, progOut}, 32'h1);
    $display("test outputs done");
  endtask
  task automatic t_stat();
    logic [3:0] exp;
    exp = 4'h0;
    for (int i = 0; i < 4; i++) begin
      plio_switch_model_i.set(i, 1'b1);
      apb(1'b0, OFF_STATUS, 32'h0);
      check(rd, {28'h0, exp});
      exp[3 - i] = 1'b1;
      tick(12);
      apb(1'b0, OFF_STATUS, 32'h0);
      check(rd, {28'h0, exp});
    end
    for (int i = 0; i < 4; i++) plio_switch_model_i.set(i, 1'b0);
    tick(14);
    $display("test status done");
  endtask
  task automatic t_trig();
    foreach (trgTab[i]) begin
      ctl(trgTab[i][13:6]);
      rise_fall(0, 0, trgTab[i][5:0]);
    end
    eng.pumping <= 1'b1;
    ctl(8'h0a);
    base = cnt;
    tick(20);
    check(32'(cnt[1] > base[1]), 32'h1);
    eng.pumping <= 1'b0;
    ctl(8'h08);
    base = cnt;
    tick(20);
    check(32'(cnt[0] > base[0]), 32'h1);
    ctl(8'h0e);
    base = cnt;
    tick(2);
    eng.stopKey <= 1'b1;
    tick(1);
    eng.stopKey <= 1'b0;
    tick(4);
    check(32'(cnt[2] - base[2]), 32'h1);
    $display("test trigger done");
  endtask
  task automatic t_dir();
    foreach (dirTab[i]) begin
      ctl({3'h0, dirTab[i][4], 4'hc});
      eng.dirInfuse <= dirTab[i][3];
      eng.keyDirOk <= dirTab[i][2];
      rise_fall(1, 3, {dirTab[i][1], 2'h0, dirTab[i][0], 2'h0});
    end
    eng <= '0;
    $display("test direction done");
  endtask
  task automatic t_prog();
    apb(1'b1, OFF_PROGCMD, 32'h0502);
    rise_fall(2, 3, 6'h02);
    check({24'h0, jumpPhase}, 32'h5);
    apb(1'b1, OFF_PROGCMD, 32'h0004);
    apb(1'b1, OFF_PROGCMD, 32'h0903);
    rise_fall(2, 3, 6'h12);
    check({24'h0, jumpPhase}, 32'h9);
    apb(1'b1, OFF_PROGCMD, 32'h0004);
    apb(1'b1, OFF_PROGCMD, 32'h0705);
    apb(1'b0, OFF_PROGRES, 32'h0);
    check(rd & 32'hffff, 32'h0703);
    plio_switch_model_i.set(3, 1'b1);
    tick(14);
    apb(1'b1, OFF_PROGCMD, 32'h0705);
    apb(1'b0, OFF_PROGRES, 32'h0);
    check(rd & 32'h3, 32'h2);
    plio_switch_model_i.set(3, 1'b0);
    ctl(8'h00);
    apb(1'b1, OFF_PROGCMD, 32'h0006);
    rise_fall(0, 3, 6'h01);
    $display("test program done");
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, eng} = '0;
    rst = 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(1);
    t_regs();
    t_out();
    t_stat();
    t_trig();
    t_dir();
    t_prog();
    report_and_stop();
  end
  // hang guard
  initial begin
    #100_000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
